// ### pkg/sysctl_defines.vh
`ifndef SYSCTL_DEFINES_VH
`define SYSCTL_DEFINES_VH

// ************************************************************
// vector addresses (high byte at even address, low byte next)
// ************************************************************
`define VEC_TIMER1_OVF   16'hffe8
`define VEC_TIMER1_CH5   16'hffea
`define VEC_TIMER1_CH4   16'hffec
`define VEC_TIMER1_CH3   16'hffee
`define VEC_TIMER1_CH2   16'hfff0
`define VEC_TIMER1_CH1   16'hfff2
`define VEC_TIMER1_CH0   16'hfff4
`define VEC_LOSS_LOCK    16'hfff6
`define VEC_WARNING      16'hfff8
`define VEC_EXT_PIN      16'hfffa
`define VEC_SOFTWARE     16'hfffc
`define VEC_RESET        16'hfffe
`define VEC_BASE         16'hffe8
`define VEC_COUNT        12

// ************************************************************
// reset cause status bit positions
// ************************************************************
`define RCS_POWER_ON     7
`define RCS_PIN          6
`define RCS_WATCHDOG     5
`define RCS_ILL_OPCODE   4
`define RCS_ILL_ADDR     3
`define RCS_LOSS_CLOCK   2
`define RCS_LOW_VOLTAGE  1
`define RCS_RESET_VAL    8'h82

// ************************************************************
// stop mode request codes
// ************************************************************
`define STOP_NONE        2'h0
`define STOP_SHALLOW     2'h1
`define STOP_DEEP        2'h2

`endif

// ### hw/vector_rom.v
`timescale 1ns/1ps
`default_nettype none
`include "sysctl_defines.vh"

// ************************************************************
// handler address table, registered byte read
// ************************************************************
module vector_rom #(
  parameter [16*`VEC_COUNT-1:0] HANDLERS = {`VEC_COUNT{16'h8000}}
) (
  input  wire       clk,
  input  wire [4:0] addr,
  output reg  [7:0] rdata
);
  wire [3:0]  idx   = addr[4:1];
  wire [15:0] entry = HANDLERS[idx*16 +: 16];

  always @(posedge clk) begin
    if (idx < `VEC_COUNT)
      rdata <= addr[0] ? entry[7:0] : entry[15:8];
    else
      rdata <= 8'h00;
  end
endmodule // vector_rom

`default_nettype wire

// ### hw/system_vector_lvd_control.v
`timescale 1ns/1ps
`default_nettype none
`include "sysctl_defines.vh"

// Contract
// - vectors rank by address; timer1 overflow lowest, reset vector highest
// - watchdog, clock loss, low voltage, pin, illegal op/address, power-on share reset
// - handler address stored high byte first, low byte at next address
// - event sets flag; request to CPU only while local enable is 1 (software has none); code sets warning flag only while warning irq enable is 1
// - low-voltage detector operates only while its enable bit is 1
// - entering stop turns detector off unless stop-enable bit set
// - detector enable plus stop-enable turns deep stop into shallow stop
// - after power-on, hold reset until supply above low threshold; set both flags
// - reset-enable bit makes low voltage raise reset; threshold picked by select bit
// - after low-voltage reset, hold until supply recovers; low-voltage flag set
// - warning with irq enable sets warning flag and requests warning vector
// - clock output off when select field is all zero
// - nonzero select drives divided bus clock on pin, overriding direction
// - software vector below reset, no enable; external pin vector below it, gated
module system_vector_lvd_control #(
  parameter       SEL_W    = 3,
  parameter [8*(1<<SEL_W)-1:0] DIV_MAP = 64'h8040201008040201,
  parameter [16*`VEC_COUNT-1:0] HANDLERS = {`VEC_COUNT{16'h8000}}
) (
  // clock and reset
  input  wire             CORE_CLK,
  input  wire             RSTN,
  // peripheral interrupt flags and local enables
  input  wire [6:0]       TIMER1_FLAGS,
  input  wire [6:0]       TIMER1_IRQ_EN,
  input  wire             LOSS_LOCK_FLAG,
  input  wire             LOSS_LOCK_IRQ_EN,
  input  wire             EXTERNAL_PIN_FLAG,
  input  wire             EXTERNAL_PIN_IRQ_ENABLE,
  input  wire             SOFTWARE_IRQ,
  // reset sources
  input  wire             WATCHDOG_ENABLE,
  input  wire             WATCHDOG_TIMEOUT,
  input  wire             CLOCK_MONITOR_ENABLE,
  input  wire             CLOCK_LOST,
  input  wire             EXT_RESET_N,
  input  wire             ILLEGAL_OPCODE,
  input  wire             ILLEGAL_ADDRESS,
  input  wire             POWER_ON,
  // voltage supervision control and analog status
  input  wire             VOLTAGE_DETECTOR_ENABLE,
  input  wire             VOLTAGE_DETECTOR_STOP_ENABLE,
  input  wire             VOLTAGE_DETECTOR_RESET_ENABLE,
  input  wire             VOLTAGE_THRESHOLD_SELECT,
  input  wire             VOLTAGE_WARNING_IRQ_ENABLE,
  input  wire             VOLTAGE_WARNING_ACK,
  input  wire             SUPPLY_BELOW_LOW,
  input  wire             SUPPLY_BELOW_HIGH,
  input  wire             SUPPLY_WARNING,
  // stop mode
  input  wire [1:0]       STOP_REQUEST,
  // vector fetch
  input  wire [4:0]       VECTOR_ADDR,
  // clock output
  input  wire [SEL_W-1:0] CLOCK_OUT_DIVIDER_SELECT,
  input  wire             PORT_A_BIT_ZERO_DATA,
  input  wire             PORT_A_BIT_ZERO_DIR,
  // outputs
  output reg              CPU_IRQ,
  output reg  [15:0]      PENDING_VECTOR,
  output wire [7:0]       VECTOR_DATA,
  output reg              SYSTEM_RESET,
  output reg  [7:0]       RESET_CAUSE_STATUS,
  output reg              VOLTAGE_WARNING_FLAG,
  output reg              DETECTOR_ACTIVE,
  output reg  [1:0]       STOP_MODE_ENTERED,
  output reg              PORT_A_BIT_ZERO_PIN_O,
  output reg              PORT_A_BIT_ZERO_PIN_OE
);

  // ************************************************************
  // reset release
  // ************************************************************
  reg rst_s1_q;
  reg rst_s2_q;
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire rst_n = rst_s2_q;

  // ************************************************************
  // detector state and stop mode
  // ************************************************************
  reg  in_stop_q;
  wire det_on = VOLTAGE_DETECTOR_ENABLE &&
                (!in_stop_q || VOLTAGE_DETECTOR_STOP_ENABLE);
  wire below_thr = VOLTAGE_THRESHOLD_SELECT ? SUPPLY_BELOW_HIGH : SUPPLY_BELOW_LOW;
  wire lv_event  = det_on && VOLTAGE_DETECTOR_RESET_ENABLE && below_thr;

  reg [1:0] stop_d;
  always @* begin
    stop_d = STOP_REQUEST;
    if (STOP_REQUEST == `STOP_DEEP && VOLTAGE_DETECTOR_ENABLE &&
        VOLTAGE_DETECTOR_STOP_ENABLE)
      stop_d = `STOP_SHALLOW;
    else if (STOP_REQUEST != `STOP_SHALLOW && STOP_REQUEST != `STOP_DEEP)
      stop_d = `STOP_NONE;
  end

  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      in_stop_q         <= 1'b0;
      STOP_MODE_ENTERED <= `STOP_NONE;
      DETECTOR_ACTIVE   <= 1'b0;
    end else begin
      in_stop_q         <= (stop_d != `STOP_NONE);
      STOP_MODE_ENTERED <= stop_d;
      DETECTOR_ACTIVE   <= det_on;
    end
  end

  // ************************************************************
  // reset sequencing and cause status
  // ************************************************************
  localparam ST_RUN     = 2'h0;
  localparam ST_POR     = 2'h1;
  localparam ST_LVHOLD  = 2'h2;
  localparam ST_OTHER   = 2'h3;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [7:0] cause_d;
  wire other_src = (WATCHDOG_ENABLE && WATCHDOG_TIMEOUT) ||
                   (CLOCK_MONITOR_ENABLE && CLOCK_LOST) ||
                   !EXT_RESET_N || ILLEGAL_OPCODE || ILLEGAL_ADDRESS;

  always @* begin
    state_d = state_q;
    cause_d = RESET_CAUSE_STATUS;
    case (state_q)
      ST_RUN: begin
        if (POWER_ON) begin
          state_d = ST_POR;
        end else if (lv_event) begin
          state_d = ST_LVHOLD;
          cause_d = 8'h00;
          cause_d[`RCS_LOW_VOLTAGE] = 1'b1;
        end else if (other_src) begin
          state_d = ST_OTHER;
          cause_d = 8'h00;
          cause_d[`RCS_PIN]        = !EXT_RESET_N;
          cause_d[`RCS_WATCHDOG]   = WATCHDOG_ENABLE && WATCHDOG_TIMEOUT;
          cause_d[`RCS_ILL_OPCODE] = ILLEGAL_OPCODE;
          cause_d[`RCS_ILL_ADDR]   = ILLEGAL_ADDRESS;
          cause_d[`RCS_LOSS_CLOCK] = CLOCK_MONITOR_ENABLE && CLOCK_LOST;
        end
      end
      ST_POR: begin
        cause_d = `RCS_RESET_VAL;
        if (!POWER_ON && !SUPPLY_BELOW_LOW)
          state_d = ST_RUN;
      end
      ST_LVHOLD: begin
        if (POWER_ON)
          state_d = ST_POR;
        else if (!below_thr)
          state_d = ST_RUN;
      end
      ST_OTHER: begin
        if (POWER_ON)
          state_d = ST_POR;
        else if (!other_src)
          state_d = ST_RUN;
      end
      default: state_d = ST_POR;
    endcase
  end

  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q            <= ST_POR;
      RESET_CAUSE_STATUS <= `RCS_RESET_VAL;
      SYSTEM_RESET       <= 1'b1;
    end else begin
      state_q            <= state_d;
      RESET_CAUSE_STATUS <= cause_d;
      SYSTEM_RESET       <= (state_d != ST_RUN);
    end
  end

  // ************************************************************
  // low-voltage warning flag
  // ************************************************************
  wire warn_set = det_on && VOLTAGE_WARNING_IRQ_ENABLE && SUPPLY_WARNING;
  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n)
      VOLTAGE_WARNING_FLAG <= 1'b0;
    else if (warn_set)
      VOLTAGE_WARNING_FLAG <= 1'b1;
    else if (VOLTAGE_WARNING_ACK)
      VOLTAGE_WARNING_FLAG <= 1'b0;
  end

  // ************************************************************
  // interrupt priority, lowest index lowest priority
  // ************************************************************
  wire [`VEC_COUNT-2:0] req;
  genvar g;
  generate
    for (g = 0; g < 7; g = g + 1) begin : g_tmr
      assign req[g] = TIMER1_FLAGS[g] && TIMER1_IRQ_EN[g];
    end
  endgenerate
  assign req[7]  = LOSS_LOCK_FLAG && LOSS_LOCK_IRQ_EN;
  assign req[8]  = VOLTAGE_WARNING_FLAG && VOLTAGE_WARNING_IRQ_ENABLE;
  assign req[9]  = EXTERNAL_PIN_FLAG && EXTERNAL_PIN_IRQ_ENABLE;
  assign req[10] = SOFTWARE_IRQ;

  reg [15:0] vec_d;
  integer i;
  always @* begin
    vec_d = `VEC_RESET;
    if (!SYSTEM_RESET) begin
      vec_d = 16'h0000;
      for (i = 0; i < `VEC_COUNT - 1; i = i + 1)
        if (req[i])
          vec_d = `VEC_BASE + {i[14:0], 1'b0};
    end
  end

  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      CPU_IRQ        <= 1'b0;
      PENDING_VECTOR <= `VEC_RESET;
    end else begin
      CPU_IRQ        <= !SYSTEM_RESET && (|req);
      PENDING_VECTOR <= vec_d;
    end
  end

  vector_rom #(
    .HANDLERS (HANDLERS)
  ) u_rom (
    .clk   (CORE_CLK),
    .addr  (VECTOR_ADDR),
    .rdata (VECTOR_DATA)
  );

  // ************************************************************
  // clock output divider
  // ************************************************************
  reg  [7:0] div_cnt_q;
  reg        clk_out_q;
  wire       clk_out_on = |CLOCK_OUT_DIVIDER_SELECT;
  wire [7:0] ratio = DIV_MAP[CLOCK_OUT_DIVIDER_SELECT*8 +: 8];
  wire [7:0] half  = (ratio > 8'h01) ? {1'b0, ratio[7:1]} : 8'h01;
  wire       tick  = (div_cnt_q + 8'h01 >= half);

  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_q              <= 8'h00;
      clk_out_q              <= 1'b0;
      PORT_A_BIT_ZERO_PIN_O  <= 1'b0;
      PORT_A_BIT_ZERO_PIN_OE <= 1'b0;
    end else begin
      if (!clk_out_on) begin
        div_cnt_q <= 8'h00;
        clk_out_q <= 1'b0;
      end else if (tick) begin
        div_cnt_q <= 8'h00;
        clk_out_q <= (ratio == 8'h01) ? 1'b1 : !clk_out_q;
      end else begin
        div_cnt_q <= div_cnt_q + 8'h01;
      end
      PORT_A_BIT_ZERO_PIN_O  <= clk_out_on ? clk_out_q : PORT_A_BIT_ZERO_DATA;
      PORT_A_BIT_ZERO_PIN_OE <= clk_out_on ? 1'b1 : PORT_A_BIT_ZERO_DIR;
    end
  end

endmodule // system_vector_lvd_control

`default_nettype wire

// ### sim/sysctl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "sysctl_defines.vh"
// ************************************************************
// port checker
// ************************************************************
module sysctl_monitor #(
  parameter SEL_W = 3
) (
  input wire logic             CORE_CLK,
  input wire logic             RSTN,
  input wire logic             POWER_ON,
  input wire logic             SUPPLY_BELOW_LOW,
  input wire logic             SUPPLY_WARNING,
  input wire logic             VOLTAGE_DETECTOR_ENABLE,
  input wire logic             VOLTAGE_DETECTOR_STOP_ENABLE,
  input wire logic             VOLTAGE_DETECTOR_RESET_ENABLE,
  input wire logic             VOLTAGE_THRESHOLD_SELECT,
  input wire logic             VOLTAGE_WARNING_IRQ_ENABLE,
  input wire logic [1:0]       STOP_REQUEST,
  input wire logic [SEL_W-1:0] CLOCK_OUT_DIVIDER_SELECT,
  input wire logic             PORT_A_BIT_ZERO_DIR,
  input wire logic             SYSTEM_RESET,
  input wire logic [7:0]       RESET_CAUSE_STATUS,
  input wire logic             VOLTAGE_WARNING_FLAG,
  input wire logic             DETECTOR_ACTIVE,
  input wire logic [1:0]       STOP_MODE_ENTERED,
  input wire logic             PORT_A_BIT_ZERO_PIN_OE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  // settles once the internal reset copy has lifted
  logic [1:0] up_q;
  always @(posedge CORE_CLK or negedge RSTN)
    if (!RSTN) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  wire live = (up_q == 2'h3);
  wire run = live && !SYSTEM_RESET;
  property p_det_off;
    live && !VOLTAGE_DETECTOR_ENABLE |=> !DETECTOR_ACTIVE;
  endproperty
  a_det_off: assert property (p_det_off) else $error("detector active while disabled");
  property p_stop_off;
    live && STOP_MODE_ENTERED != `STOP_NONE && !VOLTAGE_DETECTOR_STOP_ENABLE
      |=> !DETECTOR_ACTIVE;
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("detector kept in stop");
  property p_deep;
    run && STOP_REQUEST == `STOP_DEEP && VOLTAGE_DETECTOR_ENABLE && VOLTAGE_DETECTOR_STOP_ENABLE
      |=> STOP_MODE_ENTERED == `STOP_SHALLOW;
  endproperty
  a_deep: assert property (p_deep) else $error("deep stop not refused");
  property p_por;
    live && POWER_ON |=> SYSTEM_RESET && RESET_CAUSE_STATUS == `RCS_RESET_VAL;
  endproperty
  a_por: assert property (p_por) else $error("power-on hold wrong");
  property p_lv;
    live && VOLTAGE_DETECTOR_ENABLE && VOLTAGE_DETECTOR_RESET_ENABLE && !VOLTAGE_THRESHOLD_SELECT
      && SUPPLY_BELOW_LOW && STOP_MODE_ENTERED == `STOP_NONE
      |=> SYSTEM_RESET && RESET_CAUSE_STATUS[`RCS_LOW_VOLTAGE];
  endproperty
  a_lv: assert property (p_lv) else $error("low voltage reset missing");
  property p_warn;
    run && VOLTAGE_DETECTOR_ENABLE && STOP_MODE_ENTERED == `STOP_NONE && SUPPLY_WARNING
      && VOLTAGE_WARNING_IRQ_ENABLE |=> VOLTAGE_WARNING_FLAG;
  endproperty
  a_warn: assert property (p_warn) else $error("warning flag not set");
  property p_clk_off;
    run && CLOCK_OUT_DIVIDER_SELECT == '0 |=> PORT_A_BIT_ZERO_PIN_OE == $past(PORT_A_BIT_ZERO_DIR);
  endproperty
  a_clk_off: assert property (p_clk_off) else $error("pin enable ignores direction");
  property p_clk_on;
    run && CLOCK_OUT_DIVIDER_SELECT != '0 |=> PORT_A_BIT_ZERO_PIN_OE;
  endproperty
  a_clk_on: assert property (p_clk_on) else $error("clock output not driven");
endmodule // sysctl_monitor
bind system_vector_lvd_control sysctl_monitor #(.SEL_W(SEL_W)) i_monitor (.*);
`default_nettype wire

// ### sim/cpu_vector_fetch.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// cpu side: fetches a two-byte handler address
// ************************************************************
module cpu_vector_fetch #(
  parameter int WAIT = 2
) (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [15:0] vec,
  input  wire logic [7:0]  vdata,
  output logic      [4:0]  vaddr,
  output logic      [15:0] handler,
  output logic             done
);
  logic [2:0] st;
  int         w;
  initial begin
    st = 3'h0;
    vaddr = 5'h1f;
    handler = 16'h0000;
    done = 1'b0;
  end
  always @(posedge clk) begin
    done <= 1'b0;
    case (st)
      3'h0: if (go) begin
        vaddr <= 5'(vec - 16'hffe8);
        w <= WAIT;
        st <= 3'h4;
      end
      3'h4: if (w == 0) st <= 3'h1; else w <= w - 1;
      3'h1: begin
        vaddr <= vaddr + 5'h01;
        st <= 3'h2;
      end
      3'h2: begin
        handler[15:8] <= vdata;
        vaddr <= ~vaddr;
        st <= 3'h3;
      end
      default: begin
        handler[7:0] <= vdata;
        done <= 1'b1;
        st <= 3'h0;
      end
    endcase
  end
endmodule // cpu_vector_fetch
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sysctl_defines.vh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
// ************************************************************
// testbench
// ************************************************************
module tb;
  logic CORE_CLK = 0, RSTN = 0, POWER_ON = 1, EXT_RESET_N = 1, ILLEGAL_OPCODE = 0, go = 0;
  logic WATCHDOG_ENABLE = 0, WATCHDOG_TIMEOUT = 0, CLOCK_MONITOR_ENABLE = 0, CLOCK_LOST = 0;
  logic ILLEGAL_ADDRESS = 0, prev;
  // handler table with a distinct word per entry
  localparam logic [191:0] HND =
    192'hfe0b_fd0a_fc09_fb08_fa07_f906_f805_f704_f603_f502_f401_f300;
  logic [6:0] TIMER1_FLAGS = 0, TIMER1_IRQ_EN = 0;
  logic LOSS_LOCK_FLAG = 0, LOSS_LOCK_IRQ_EN = 0, EXTERNAL_PIN_FLAG = 0, SOFTWARE_IRQ = 0;
  logic EXTERNAL_PIN_IRQ_ENABLE = 0, SUPPLY_BELOW_LOW = 0, SUPPLY_BELOW_HIGH = 0;
  logic VOLTAGE_DETECTOR_ENABLE = 0, VOLTAGE_DETECTOR_STOP_ENABLE = 0, SUPPLY_WARNING = 0;
  logic VOLTAGE_DETECTOR_RESET_ENABLE = 0, VOLTAGE_THRESHOLD_SELECT = 0, done;
  logic VOLTAGE_WARNING_IRQ_ENABLE = 0, VOLTAGE_WARNING_ACK = 0;
  logic PORT_A_BIT_ZERO_DATA = 0, PORT_A_BIT_ZERO_DIR = 0, CPU_IRQ, SYSTEM_RESET;
  logic [1:0] STOP_REQUEST = 0, STOP_MODE_ENTERED;
  logic [2:0] CLOCK_OUT_DIVIDER_SELECT = 0;
  logic [4:0] VECTOR_ADDR;
  logic [15:0] PENDING_VECTOR, hnd;
  logic [7:0] VECTOR_DATA, RESET_CAUSE_STATUS;
  logic VOLTAGE_WARNING_FLAG, DETECTOR_ACTIVE, PORT_A_BIT_ZERO_PIN_O, PORT_A_BIT_ZERO_PIN_OE;
  int fail_count = 0, check_count = 0, n, r;
  system_vector_lvd_control #(.HANDLERS(HND)) i_dut (.*);
  cpu_vector_fetch i_cpu (.clk(CORE_CLK), .go(go), .vec(PENDING_VECTOR), .vdata(VECTOR_DATA),
    .vaddr(VECTOR_ADDR), .handler(hnd), .done(done));
  initial forever #2.5 CORE_CLK = ~CORE_CLK;
  task cyc(input int k);
    repeat (k) @(posedge CORE_CLK);
    #1;
  endtask
  task results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #20000;
    fail_count++;
    results();
  end
  initial begin
    repeat (5) @(posedge CORE_CLK);
    RSTN <= 1;
    cyc(4);
    `CHK("por hold", 1'b1, SYSTEM_RESET)
    `CHK("por vector", {1'b0, `VEC_RESET}, {CPU_IRQ, PENDING_VECTOR})
    @(posedge CORE_CLK) POWER_ON <= 0;
    cyc(2);
    `CHK("por status", {1'b0, `RCS_RESET_VAL}, {SYSTEM_RESET, RESET_CAUSE_STATUS})
    $display("test power-on done");
    @(posedge CORE_CLK) TIMER1_IRQ_EN <= 7'h7f;
    for (n = 0; n < 7; n++) begin
      @(posedge CORE_CLK) TIMER1_FLAGS[n] <= 1;
      cyc(1);
      `CHK("pending", 16'hffe8 + 16'(2 * n), PENDING_VECTOR)
    end
    @(posedge CORE_CLK) {LOSS_LOCK_FLAG, LOSS_LOCK_IRQ_EN, EXTERNAL_PIN_FLAG} <= 3'h7;
    cyc(1);
    `CHK("masked pin", `VEC_LOSS_LOCK, PENDING_VECTOR)
    @(posedge CORE_CLK) EXTERNAL_PIN_IRQ_ENABLE <= 1;
    cyc(1);
    `CHK("pin", `VEC_EXT_PIN, PENDING_VECTOR)
    @(posedge CORE_CLK) SOFTWARE_IRQ <= 1;
    cyc(1);
    `CHK("soft", {1'b1, `VEC_SOFTWARE}, {CPU_IRQ, PENDING_VECTOR})
    @(posedge CORE_CLK) {TIMER1_IRQ_EN, LOSS_LOCK_IRQ_EN, EXTERNAL_PIN_IRQ_ENABLE} <= 0;
    SOFTWARE_IRQ <= 0;
    cyc(1);
    `CHK("all masked", 17'h0, {CPU_IRQ, PENDING_VECTOR})
    @(posedge CORE_CLK) {VOLTAGE_DETECTOR_ENABLE, VOLTAGE_WARNING_IRQ_ENABLE} <= 2'h3;
    SUPPLY_WARNING <= 1;
    cyc(2);
    `CHK("warning", {1'b1, `VEC_WARNING}, {VOLTAGE_WARNING_FLAG, PENDING_VECTOR})
    @(posedge CORE_CLK) go <= 1;
    @(posedge CORE_CLK) go <= 0;
    for (r = 0; done !== 1'b1 && r < 20; r++) cyc(1);
    `CHK("fetch done", 1'b1, done)
    `CHK("handler", HND[16 * 8 +: 16], hnd)
    @(posedge CORE_CLK) SUPPLY_WARNING <= 0;
    cyc(2);
    `CHK("sticky", 1'b1, VOLTAGE_WARNING_FLAG)
    @(posedge CORE_CLK) VOLTAGE_WARNING_ACK <= 1;
    @(posedge CORE_CLK) SUPPLY_WARNING <= 1;
    #1;
    `CHK("ack", 1'b0, VOLTAGE_WARNING_FLAG)
    @(posedge CORE_CLK) SUPPLY_WARNING <= 0;
    #1;
    `CHK("set wins", 1'b1, VOLTAGE_WARNING_FLAG)
    @(posedge CORE_CLK) VOLTAGE_WARNING_ACK <= 0;
    cyc(1);
    `CHK("ack again", 1'b0, VOLTAGE_WARNING_FLAG)
    $display("test vectors done");
    @(posedge CORE_CLK) {VOLTAGE_DETECTOR_RESET_ENABLE, SUPPLY_BELOW_LOW, SOFTWARE_IRQ} <= 3'h7;
    cyc(4);
    `CHK("lv reset", 10'h202, {SYSTEM_RESET, CPU_IRQ, RESET_CAUSE_STATUS})
    `CHK("reset vector", `VEC_RESET, PENDING_VECTOR)
    @(posedge CORE_CLK) {SUPPLY_BELOW_LOW, SOFTWARE_IRQ} <= 0;
    cyc(2);
    `CHK("lv release", 1'b0, SYSTEM_RESET)
    @(posedge CORE_CLK) {VOLTAGE_THRESHOLD_SELECT, SUPPLY_BELOW_HIGH} <= 2'h3;
    cyc(1);
    `CHK("high threshold", 1'b1, SYSTEM_RESET)
    @(posedge CORE_CLK) {VOLTAGE_DETECTOR_RESET_ENABLE, SUPPLY_BELOW_HIGH} <= 0;
    cyc(2);
    $display("test low voltage done");
    for (n = 0; n < 12; n++) begin
      @(posedge CORE_CLK) STOP_REQUEST <= 2'(n >> 2);
      {VOLTAGE_DETECTOR_ENABLE, VOLTAGE_DETECTOR_STOP_ENABLE} <= 2'(n);
      cyc(1);
      `CHK("stop", (n == 11) ? `STOP_SHALLOW : 2'(n >> 2), STOP_MODE_ENTERED)
      `CHK("detector", n[1] && (n < 4 || n[0]), DETECTOR_ACTIVE)
    end
    @(posedge CORE_CLK) STOP_REQUEST <= `STOP_NONE;
    {PORT_A_BIT_ZERO_DIR, PORT_A_BIT_ZERO_DATA} <= 2'h3;
    cyc(1);
    `CHK("port pin", 2'h3, {PORT_A_BIT_ZERO_PIN_OE, PORT_A_BIT_ZERO_PIN_O})
    for (n = 1; n < 4; n++) begin
      @(posedge CORE_CLK) CLOCK_OUT_DIVIDER_SELECT <= 3'(n);
      PORT_A_BIT_ZERO_DIR <= 0;
      cyc(20);
      r = 0;
      repeat (64) begin
        prev = PORT_A_BIT_ZERO_PIN_O;
        cyc(1);
        r += int'(prev === 1'b0 && PORT_A_BIT_ZERO_PIN_O === 1'b1);
      end
      `CHK("clock rises", 64 >> n, r)
      `CHK("clock drives pin", 1'b1, PORT_A_BIT_ZERO_PIN_OE)
    end
    $display("test stop and clock done");
    @(posedge CORE_CLK) ILLEGAL_OPCODE <= 1;
    cyc(1);
    `CHK("ilop", 2'h3, {SYSTEM_RESET, RESET_CAUSE_STATUS[`RCS_ILL_OPCODE]})
    @(posedge CORE_CLK) ILLEGAL_OPCODE <= 0;
    cyc(4);
    @(posedge CORE_CLK) EXT_RESET_N <= 0;
    cyc(1);
    `CHK("pin reset", 2'h3, {SYSTEM_RESET, RESET_CAUSE_STATUS[`RCS_PIN]})
    @(posedge CORE_CLK) EXT_RESET_N <= 1;
    WATCHDOG_TIMEOUT <= 1;
    cyc(3);
    `CHK("wdog masked", 1'b0, SYSTEM_RESET)
    @(posedge CORE_CLK) WATCHDOG_ENABLE <= 1;
    cyc(1);
    `CHK("wdog", 2'h3, {SYSTEM_RESET, RESET_CAUSE_STATUS[`RCS_WATCHDOG]})
    @(posedge CORE_CLK) WATCHDOG_TIMEOUT <= 0;
    cyc(2);
    @(posedge CORE_CLK) {CLOCK_MONITOR_ENABLE, CLOCK_LOST} <= 2'h3;
    cyc(1);
    `CHK("clock loss", 2'h3, {SYSTEM_RESET, RESET_CAUSE_STATUS[`RCS_LOSS_CLOCK]})
    @(posedge CORE_CLK) CLOCK_LOST <= 0;
    cyc(2);
    @(posedge CORE_CLK) ILLEGAL_ADDRESS <= 1;
    cyc(1);
    `CHK("illegal address", 9'h108, {SYSTEM_RESET, RESET_CAUSE_STATUS})
    $display("test reset sources done");
    results();
  end
endmodule // tb
`default_nettype wire
